// file: hw/cfc_changeover_ctrl.sv
// The register offsets and the APB register port were left to the implementer.
`default_nettype none
// Function
// - one common source select for all channels
// - no-measurement channels never fault or switch
// - fault thresholds fixed constants, not settable
// - amplitude window or loss-of-signal per type
// - automatic and manual operating modes
// - auto: fault table maps to source
// - auto returns to primary once repaired
// - manual: operator choice, faults ignored
// - backup request accepted only in manual
// - per-input fault latches stay set until clear or channel disabled
// - report lowest faulty configured channel
// - repaired state until clear, then off
// - per-channel error flags with levels readable
// - twelve channel type options per channel
// - only channels up to count monitored
// - levels normalised; missing input reads minimum
// - channel count accepts one to twelve
// - power loss falls back to primary
// - start auto, primary selected
module cfc_changeover_ctrl #(
  parameter int NCH = cfc_pkg::NCH_DEF,
  parameter int CW  = $clog2(NCH + 1)
) (
  input  wire logic                   pclk,           // system clock
  input  wire logic                   presetn,        // async reset, low active
  input  wire logic                   psel,           // apb select
  input  wire logic                   penable,        // apb enable
  input  wire logic                   pwrite,         // apb direction
  input  wire logic [11:0]            paddr,          // apb byte address
  input  wire logic [31:0]            pwdata,         // apb write data
  output logic      [31:0]            prdata,         // apb read data
  output logic                        pready,         // apb ready
  output logic                        pslverr,        // apb error
  input  wire cfc_pkg::cfc_in_t [NCH-1:0] prim_in,    // primary detectors
  input  wire cfc_pkg::cfc_in_t [NCH-1:0] back_in,    // backup detectors
  input  wire logic                   power_lost,     // supply failing
  output logic                        src_backup,     // common select, 1 backup
  output logic                        manual_mode,    // 1 manual
  output logic                        fault_ind,      // fault indication
  output logic                        fault_repaired, // all faults repaired
  output logic      [CW-1:0]          fault_chan      // lowest faulty, 0 none
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  cfc_pkg::cfc_in_t [NCH-1:0] prim_m_r, prim_s_r;
  cfc_pkg::cfc_in_t [NCH-1:0] back_m_r, back_s_r;
  logic                       pwr_m_r,  pwr_s_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prim_m_r <= '0;
      prim_s_r <= '0;
      back_m_r <= '0;
      back_s_r <= '0;
      pwr_m_r  <= 1'b0;
      pwr_s_r  <= 1'b0;
    end
    else
    begin
      prim_m_r <= prim_in;
      prim_s_r <= prim_m_r;
      back_m_r <= back_in;
      back_s_r <= back_m_r;
      pwr_m_r  <= power_lost;
      pwr_s_r  <= pwr_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state declarations
  cfc_pkg::cfc_chan_type_t [NCH-1:0] type_r;
  cfc_pkg::cfc_chan_type_t [NCH-1:0] type_nxt;
  logic                   mode_r,     mode_nxt;
  logic                   man_sel_r,  man_sel_nxt;
  logic [CW-1:0]          count_r,    count_nxt;
  logic [NCH-1:0]         primary_error_flag_r,     primary_error_flag_nxt;
  logic [NCH-1:0]         backup_error_flag_r,     backup_error_flag_nxt;
  logic                   src_r,      src_nxt;
  logic                   ind_r,      ind_nxt;
  logic                   rep_r,      rep_nxt;
  logic [CW-1:0]          chan_r,     chan_nxt;
  logic [31:0]            prdata_r,   prdata_nxt;
  logic                   pready_r,   pready_nxt;
  logic                   pslverr_r,  pslverr_nxt;
  logic [NCH-1:0]         p_fault,    b_fault;
  logic [NCH-1:0]         chan_en;
  logic [NCH-1:0]         p_live,     b_live;
  logic [cfc_pkg::LVL_W-1:0] p_norm [NCH], b_norm [NCH];
  logic                   wr_en,      clr_req;

  function automatic logic in_rng(input logic [11:0] a, input logic [11:0] base);
    return (int'(a) >= int'(base)) && (int'(a) < int'(base) + 4 * NCH) && (a[1:0] == 2'b00);
  endfunction

  function automatic int reg_idx(input logic [11:0] a, input logic [11:0] base);
    return (int'(a) - int'(base)) / 4;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-input judges
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_chan
      cfc_input_judge u_prim (
        .chan_type  (type_r[g]),
        .sig        (prim_s_r[g]),
        .fault      (p_fault[g]),
        .norm_level (p_norm[g])
      );
      cfc_input_judge u_back (
        .chan_type  (type_r[g]),
        .sig        (back_s_r[g]),
        .fault      (b_fault[g]),
        .norm_level (b_norm[g])
      );
      assign chan_en[g] = (g < int'(count_r)) && (type_r[g] != cfc_pkg::CT_NONE);
      assign p_live[g]  = chan_en[g] && p_fault[g];
      assign b_live[g]  = chan_en[g] && b_fault[g];
    end
  endgenerate

  assign wr_en   = psel && penable && pready_r && pwrite;
  assign clr_req = wr_en && (paddr == cfc_pkg::OFS_CLEAR) && pwdata[cfc_pkg::CLEAR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  always_comb
  begin
    pready_nxt  = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    if (psel && !penable)
    begin
      prdata_nxt = '0;
      if (paddr == cfc_pkg::OFS_CTRL)
        prdata_nxt = 32'({man_sel_r, mode_r});
      else if (paddr == cfc_pkg::OFS_CHCNT)
        prdata_nxt = 32'(count_r);
      else if (paddr == cfc_pkg::OFS_CLEAR)
        prdata_nxt = '0;
      else if (paddr == cfc_pkg::OFS_STATUS)
        prdata_nxt = 32'({chan_r, rep_r, ind_r, mode_r, src_r});
      else if (in_rng(paddr, cfc_pkg::OFS_TYPE_BASE))
        prdata_nxt = 32'(type_r[reg_idx(paddr, cfc_pkg::OFS_TYPE_BASE)]);
      else if (in_rng(paddr, cfc_pkg::OFS_CHST_BASE))
      begin
        prdata_nxt = {6'h00, b_live[reg_idx(paddr, cfc_pkg::OFS_CHST_BASE)],
                      p_live[reg_idx(paddr, cfc_pkg::OFS_CHST_BASE)],
                      b_norm[reg_idx(paddr, cfc_pkg::OFS_CHST_BASE)],
                      p_norm[reg_idx(paddr, cfc_pkg::OFS_CHST_BASE)], 6'h00,
                      backup_error_flag_r[reg_idx(paddr, cfc_pkg::OFS_CHST_BASE)],
                      primary_error_flag_r[reg_idx(paddr, cfc_pkg::OFS_CHST_BASE)]};
      end
      else
        pslverr_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operator settings
  always_comb
  begin
    mode_nxt    = mode_r;
    man_sel_nxt = man_sel_r;
    count_nxt   = count_r;
    type_nxt    = type_r;
    if (wr_en && (paddr == cfc_pkg::OFS_CTRL))
    begin
      mode_nxt = pwdata[cfc_pkg::CTRL_MODE_BIT];
      man_sel_nxt = mode_r && pwdata[cfc_pkg::CTRL_SEL_BIT];
    end
    if (wr_en && (paddr == cfc_pkg::OFS_CHCNT) && (pwdata >= 32'h1) && (int'(pwdata) <= NCH))
      count_nxt = CW'(pwdata);
    for (int i = 0; i < NCH; i++)
    begin
      if (wr_en && in_rng(paddr, cfc_pkg::OFS_TYPE_BASE)
          && (reg_idx(paddr, cfc_pkg::OFS_TYPE_BASE) == i)
          && (pwdata[3:0] < cfc_pkg::NUM_TYPES) && (pwdata[31:4] == 28'h0))
        type_nxt[i] = cfc_pkg::cfc_chan_type_t'(pwdata[3:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r    <= cfc_pkg::MODE_RST;
      man_sel_r <= cfc_pkg::SEL_RST;
      count_r   <= CW'(cfc_pkg::CHCNT_RST);
      type_r    <= {NCH{cfc_pkg::TYPE_RST}};
    end
    else
    begin
      mode_r    <= mode_nxt;
      man_sel_r <= man_sel_nxt;
      count_r   <= count_nxt;
      type_r    <= type_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault latches, selection and report
  always_comb
  begin
    primary_error_flag_nxt = p_live | (primary_error_flag_r & chan_en & {NCH{!clr_req}});
    backup_error_flag_nxt = b_live | (backup_error_flag_r & chan_en & {NCH{!clr_req}});
    src_nxt = pwr_s_r ? 1'b0 : (mode_r ? man_sel_r : (|p_live));
    ind_nxt = (|primary_error_flag_nxt) || (|backup_error_flag_nxt);
    rep_nxt = ind_nxt && !(|p_live) && !(|b_live);
    chan_nxt = '0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (p_live[i] || b_live[i])
      begin
        chan_nxt = CW'(i + 1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      primary_error_flag_r <= '0;
      backup_error_flag_r <= '0;
      src_r  <= 1'b0;
      ind_r  <= 1'b0;
      rep_r  <= 1'b0;
      chan_r <= '0;
    end
    else
    begin
      primary_error_flag_r <= primary_error_flag_nxt;
      backup_error_flag_r <= backup_error_flag_nxt;
      src_r  <= src_nxt;
      ind_r  <= ind_nxt;
      rep_r  <= rep_nxt;
      chan_r <= chan_nxt;
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign src_backup     = src_r;
  assign manual_mode    = mode_r;
  assign fault_ind      = ind_r;
  assign fault_repaired = rep_r;
  assign fault_chan     = chan_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_clear_write;
    wr_en && (paddr == cfc_pkg::OFS_CLEAR) && pwdata[cfc_pkg::CLEAR_BIT];
  endsequence

  sequence s_ctrl_write_auto;
    wr_en && (paddr == cfc_pkg::OFS_CTRL) && !mode_r;
  endsequence

  AST_AUTO_PRIM_FAULT: assert property (!mode_r && !pwr_s_r && (|p_live) |=> src_backup)
    else $error("auto primary fault did not select backup");
  AST_AUTO_RETURN: assert property (!mode_r && !(|p_live) |=> !src_backup)
    else $error("auto did not return to primary");
  AST_MANUAL_SEL: assert property (mode_r && !pwr_s_r |=> src_backup == $past(man_sel_r))
    else $error("manual select not followed");
  AST_BACKUP_REQ_AUTO: assert property (s_ctrl_write_auto |=> !man_sel_r)
    else $error("backup request taken in auto mode");
  AST_LATCH_STICKY: assert property (primary_error_flag_r[0] && chan_en[0] && !clr_req |=> primary_error_flag_r[0])
    else $error("primary fault latch dropped");
  AST_NOMEAS_NOFLAG: assert property ($rose(primary_error_flag_r[0]) |-> $past(type_r[0]) != cfc_pkg::CT_NONE)
    else $error("fault latched on unmeasured channel");
  AST_REPORT_LOWEST: assert property ((p_live[0] || b_live[0]) |=> fault_chan == CW'(1))
    else $error("lowest faulty channel not reported");
  AST_CLEAR_OFF: assert property (s_clear_write ##0 (!(|p_live) && !(|b_live))
                                  |=> !fault_ind && !fault_repaired)
    else $error("clear did not turn indication off");
  AST_REPAIRED: assert property (fault_ind && !clr_req && !(|p_live) && !(|b_live)
                                 && ((primary_error_flag_r & chan_en) != '0 || (backup_error_flag_r & chan_en) != '0)
                                 |=> fault_repaired)
    else $error("repaired state missing");
  AST_COUNT_RANGE: assert property (count_r >= CW'(1) && int'(count_r) <= NCH)
    else $error("channel count out of range");
  AST_POWER_PRIMARY: assert property (pwr_s_r |=> !src_backup)
    else $error("power loss did not select primary");

endmodule // cfc_changeover_ctrl
`default_nettype wire

// file: hw/cfc_input_judge.sv
`default_nettype none
module cfc_input_judge (
  input  wire cfc_pkg::cfc_chan_type_t chan_type,  // configured channel type
  input  wire cfc_pkg::cfc_in_t        sig,        // synchronised detector sample
  output logic                         fault,      // live fault of this input
  output logic [cfc_pkg::LVL_W-1:0]    norm_level  // level scaled to nominal
);

  int nom;
  int lo_thr;
  int hi_thr;
  int lvl;
  int scaled;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nom    = cfc_pkg::nominal_code(chan_type);
    lo_thr = (nom * cfc_pkg::FAULT_LO_PCT) / 100;
    hi_thr = (nom * cfc_pkg::FAULT_HI_PCT) / 100;
    lvl    = int'(sig.level);
    if (nom == 0)
    begin
      scaled = 0;
    end
    else
    begin
      scaled = (lvl * cfc_pkg::NORM_FULL) / nom;
    end
    if (sig.los)
    begin
      norm_level = '0;
    end
    else if (scaled > cfc_pkg::LVL_MAX)
    begin
      norm_level = cfc_pkg::LVL_W'(cfc_pkg::LVL_MAX);
    end
    else
    begin
      norm_level = cfc_pkg::LVL_W'(scaled);
    end
    if (chan_type == cfc_pkg::CT_NONE)
    begin
      fault = 1'b0;
    end
    else if (cfc_pkg::is_amp_type(chan_type))
    begin
      fault = sig.los || (lvl < lo_thr) || (lvl > hi_thr);
    end
    else
    begin
      fault = sig.los;
    end
  end

endmodule // cfc_input_judge
`default_nettype wire

// file: hw/cfc_pkg.sv
`default_nettype none
package cfc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NCH_DEF   = 12;
  localparam int LVL_W     = 8;
  localparam int LVL_MAX   = 255;
  localparam int LSB_MV    = 20;
  localparam int NORM_FULL = 128;

  ////////////////////////////////////////////////////////////////////////////
  // channel types
  typedef enum logic [3:0] {
    CT_NONE,
    CT_BLACK,
    CT_BLACK_ANC,
    CT_TRILEVEL,
    CT_SD_LOS,
    CT_HD_LOS,
    CT_3G_LOS,
    CT_CLK_1V,
    CT_SUBC_1V,
    CT_AUDIO_1V,
    CT_PULSE2_LOS,
    CT_PULSE4_LOS
  } cfc_chan_type_t;

  localparam logic [3:0] NUM_TYPES = 4'hc;

  // one detector sample: loss-of-signal and measured amplitude
  typedef struct packed {
    logic             los;
    logic [LVL_W-1:0] level;
  } cfc_in_t;

  ////////////////////////////////////////////////////////////////////////////
  // fixed nominal amplitudes and fault window, not software adjustable
  localparam int NOM_BLACK_MV = 300;
  localparam int NOM_TRI_MV   = 600;
  localparam int NOM_SDI_MV   = 800;
  localparam int NOM_1V_MV    = 1000;
  localparam int NOM_2V_MV    = 2000;
  localparam int NOM_4V_MV    = 4000;
  localparam int FAULT_LO_PCT = 75;
  localparam int FAULT_HI_PCT = 125;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_CHCNT     = 12'h004;
  localparam logic [11:0] OFS_CLEAR     = 12'h008;
  localparam logic [11:0] OFS_STATUS    = 12'h00c;
  localparam logic [11:0] OFS_TYPE_BASE = 12'h010;
  localparam logic [11:0] OFS_CHST_BASE = 12'h040;
  localparam int          CTRL_MODE_BIT = 0;
  localparam int          CTRL_SEL_BIT  = 1;
  localparam int          CLEAR_BIT     = 0;

  // reset values
  localparam logic           MODE_RST  = 1'b0;
  localparam logic           SEL_RST   = 1'b0;
  localparam int             CHCNT_RST = 1;
  localparam cfc_chan_type_t TYPE_RST  = CT_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // nominal amplitude in detector codes
  function automatic int nominal_code(input cfc_chan_type_t t);
    case (t)
      CT_BLACK, CT_BLACK_ANC:           return NOM_BLACK_MV / LSB_MV;
      CT_TRILEVEL:                      return NOM_TRI_MV / LSB_MV;
      CT_SD_LOS, CT_HD_LOS, CT_3G_LOS:  return NOM_SDI_MV / LSB_MV;
      CT_CLK_1V, CT_SUBC_1V, CT_AUDIO_1V: return NOM_1V_MV / LSB_MV;
      CT_PULSE2_LOS:                    return NOM_2V_MV / LSB_MV;
      CT_PULSE4_LOS:                    return NOM_4V_MV / LSB_MV;
      default:                          return 0;
    endcase
  endfunction

  // types judged by amplitude window rather than loss of signal only
  function automatic logic is_amp_type(input cfc_chan_type_t t);
    case (t)
      CT_BLACK, CT_BLACK_ANC, CT_TRILEVEL,
      CT_CLK_1V, CT_SUBC_1V, CT_AUDIO_1V: return 1'b1;
      default:                            return 1'b0;
    endcase
  endfunction

endpackage
`default_nettype wire

// file: tb/cfc_det_model.sv
`default_nettype none
module cfc_det_model #(
  parameter int NCH = 12
) (
  input  wire logic                      pclk,    // system clock
  input  wire logic [NCH-1:0]            bad_p,   // primary input missing
  input  wire logic [NCH-1:0]            bad_b,   // backup input missing
  input  wire logic [7:0]                lvl_p,   // primary amplitude code
  input  wire logic [7:0]                lvl_b,   // backup amplitude code
  output var  cfc_pkg::cfc_in_t [NCH-1:0] prim_in, // primary detector samples
  output var  cfc_pkg::cfc_in_t [NCH-1:0] back_in  // backup detector samples
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] noise = 8'h5a;

  ////////////////////////////////////////////////////////////////////////////
  // missing input shows noise
  // a lost input carries no steady level, so the amplitude wanders
  always @(posedge pclk)
  begin
    noise <= {noise[6:0], noise[7] ^ noise[5]};
    for (int i = 0; i < NCH; i++)
    begin
      prim_in[i] <= {bad_p[i], bad_p[i] ? noise : lvl_p};
      back_in[i] <= {bad_b[i], bad_b[i] ? ~noise : lvl_b};
    end
  end
endmodule // cfc_det_model
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int NCH    = 12;
  localparam int SETTLE = 5;

  logic                       pclk, presetn, psel, penable, pwrite, power_lost;
  logic [11:0]                paddr;
  logic [31:0]                pwdata, prdata, rd;
  logic                       pready, pslverr, err;
  logic                       src_backup, manual_mode, fault_ind, fault_repaired;
  logic [3:0]                 fault_chan;
  logic [NCH-1:0]             bad_p, bad_b;
  logic [7:0]                 lvl_p, lvl_b;
  cfc_pkg::cfc_in_t [NCH-1:0] prim_in, back_in;
  int                         miscompares, comparisons;
  logic [7:0]                 lv [4];
  logic                       lx [4];

  cfc_changeover_ctrl #(.NCH(NCH)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prim_in(prim_in), .back_in(back_in),
    .power_lost(power_lost), .src_backup(src_backup), .manual_mode(manual_mode),
    .fault_ind(fault_ind), .fault_repaired(fault_repaired), .fault_chan(fault_chan)
  );

  cfc_det_model #(.NCH(NCH)) det_u (
    .pclk(pclk), .bad_p(bad_p), .bad_b(bad_b), .lvl_p(lvl_p), .lvl_b(lvl_b),
    .prim_in(prim_in), .back_in(back_in)
  );

  always #4 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 50)
      miscompares++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic settle;
    repeat (SETTLE) @(posedge pclk);
  endtask

  function automatic logic [11:0] ta(input int i);
    return cfc_pkg::OFS_TYPE_BASE + 12'(4 * i);
  endfunction

  function automatic logic [31:0] st(input logic sb, md, ind, rep, input logic [3:0] ch);
    return {24'h0, ch, rep, ind, md, sb};
  endfunction

  task automatic print_verdict;
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end

  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; power_lost = 1'b0; bad_p = '0; bad_b = '0;
    lvl_p = 8'h0f; lvl_b = 8'h0f; miscompares = 0; comparisons = 0;
    lv = '{8'h0a, 8'h0b, 8'h12, 8'h13};
    lx = '{1'b1, 1'b0, 1'b0, 1'b1};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(cfc_pkg::OFS_CTRL, 32'h0);
    rd_chk(cfc_pkg::OFS_CHCNT, 32'h1);
    rd_chk(cfc_pkg::OFS_STATUS, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h002, 32'h3);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, cfc_pkg::OFS_STATUS, 32'hff);
    rd_chk(cfc_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, cfc_pkg::OFS_CHCNT, 32'h0);
    apb(1'b1, cfc_pkg::OFS_CHCNT, 32'hd);
    rd_chk(cfc_pkg::OFS_CHCNT, 32'h1);
    apb(1'b1, cfc_pkg::OFS_CHCNT, 32'hc);
    rd_chk(cfc_pkg::OFS_CHCNT, 32'hc);
    for (int i = 0; i < NCH; i++)
      apb(1'b1, ta(i), 32'(i));
    for (int i = 0; i < NCH; i++)
      rd_chk(ta(i), 32'(i));
    apb(1'b1, ta(1), 32'hc);
    rd_chk(ta(1), 32'h1);
    apb(1'b1, cfc_pkg::OFS_CHCNT, 32'h1);
    apb(1'b1, ta(0), 32'h1);
    // channels beyond the count and a no-measurement channel stay quiet
    bad_p <= 12'hffe;
    settle();
    rd_chk(cfc_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, ta(0), 32'h0);
    bad_p <= 12'hfff;
    settle();
    rd_chk(cfc_pkg::OFS_STATUS, 32'h0);
    bad_p <= '0;
    apb(1'b1, ta(0), 32'h1);
    apb(1'b1, cfc_pkg::OFS_CLEAR, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      bad_p <= {11'h0, k[0]};
      bad_b <= {11'h0, k[1]};
      settle();
      chk({31'h0, src_backup}, {31'h0, k[0]});
    end
    bad_p <= '0;
    bad_b <= '0;
    settle();
    chk({31'h0, src_backup}, 32'h0);
    rd_chk(cfc_pkg::OFS_STATUS, st(0, 0, 1, 1, 4'h0));
    apb(1'b1, cfc_pkg::OFS_CLEAR, 32'h1);
    rd_chk(cfc_pkg::OFS_STATUS, 32'h0);
    bad_p <= 12'h001;
    repeat (2) @(posedge pclk);
    bad_p <= '0;
    settle();
    chk({30'h0, fault_ind, src_backup}, 32'h2);
    apb(1'b1, cfc_pkg::OFS_CLEAR, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      lvl_p <= lv[k];
      settle();
      chk({31'h0, src_backup}, {31'h0, lx[k]});
    end
    apb(1'b1, ta(0), 32'h4);
    lvl_p <= 8'h02;
    settle();
    chk({31'h0, src_backup}, 32'h0);
    apb(1'b1, ta(0), 32'h1);
    lvl_p <= 8'h0f;
    settle();
    apb(1'b1, cfc_pkg::OFS_CLEAR, 32'h1);
    bad_b <= 12'h001;
    settle();
    rd_chk(cfc_pkg::OFS_CHST_BASE, 32'h0200_8002);
    apb(1'b1, cfc_pkg::OFS_CHCNT, 32'h3);
    apb(1'b1, ta(1), 32'h1);
    apb(1'b1, ta(2), 32'h1);
    bad_b <= 12'h006;
    settle();
    chk({28'h0, fault_chan}, 32'h2);
    bad_b <= 12'h004;
    settle();
    chk({28'h0, fault_chan}, 32'h3);
    bad_b <= '0;
    settle();
    chk({29'h0, fault_chan == 4'h0, fault_repaired, fault_ind}, 32'h7);
    apb(1'b1, cfc_pkg::OFS_CTRL, 32'h2);
    rd_chk(cfc_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, cfc_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, cfc_pkg::OFS_CTRL, 32'h3);
    bad_b <= 12'h001;
    settle();
    chk({30'h0, manual_mode, src_backup}, 32'h3);
    apb(1'b1, cfc_pkg::OFS_CTRL, 32'h1);
    bad_b <= '0;
    bad_p <= 12'h001;
    settle();
    chk({30'h0, manual_mode, src_backup}, 32'h2);
    apb(1'b1, cfc_pkg::OFS_CTRL, 32'h3);
    power_lost <= 1'b1;
    settle();
    chk({31'h0, src_backup}, 32'h0);
    power_lost <= 1'b0;
    settle();
    chk({31'h0, src_backup}, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(cfc_pkg::OFS_CTRL, 32'h0);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
